// [bench/position_selector_switch_tb_top.sv]
// Self-checking bench for the position selector switch
module position_selector_switch_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short tick keeps the 3 s figures at 600 cycles
  localparam int TC = 2;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        por_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp;
  logic [2:0]  reqs = 3'h0;
  logic [2:0]  code_req = 3'h0;
  logic        step_input, step_confirm_input, code_confirm_input;
  logic        code_bit0_input, code_bit1_input, code_bit2_input;
  logic [2:0]  position;
  logic [6:0]  position_flags;
  logic        position_in_use, change_initiated, step_confirm_alarm;
  logic        code_range_alarm, startup_alarm, code_confirm_alarm;
  logic [3:0]  ev;
  logic [31:0] r;
  int          n;
  int          miscompares = 0;
  int          checks_done = 0;
  // Code word, expected position, awaited event
  logic [11:0] rows [7] = '{12'h111, 12'h221, 12'h331, 12'h441, 12'h551, 12'h752, 12'h661};

  assign ev = {change_initiated, step_confirm_alarm, code_range_alarm, position_in_use};
  always #50 hclk = ~hclk;

  sps_selector_top #(.TICK_CYCLES(TC)) dut (
    .hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .step_input, .step_confirm_input, .code_bit0_input, .code_bit1_input,
    .code_bit2_input, .code_confirm_input, .position, .position_flags,
    .position_in_use, .change_initiated, .step_confirm_alarm,
    .code_confirm_alarm, .code_range_alarm, .startup_alarm
  );
  sps_ctl_model #(.GAP(5 * TC)) u_ctl (
    .hclk, .reqs, .code_req, .step_input, .step_confirm_input, .code_confirm_input,
    .code_bit0_input, .code_bit1_input, .code_bit2_input
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single word transfer; only the watchdog ends a stalled wait
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sps_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic req(input logic [2:0] m);
    @(posedge hclk);
    reqs <= m;
    @(posedge hclk);
    reqs <= 3'h0;
  endtask
  // Cycles until an event in the mask, capped at lim
  task automatic wait_ev(input logic [3:0] m, input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((|(ev & m)) !== 1'b1 && n < lim);
  endtask
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #3_000_000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(32'(startup_alarm), 32'h1);
    chk(32'(position), 32'h0);
    // Timeout clamps, top of six, stray address
    bus(1'b1, sps_pkg::ADDR_TIMEOUT, 32'h5);
    bus(1'b0, sps_pkg::ADDR_TIMEOUT, 32'h0);
    chk(r, 32'(sps_pkg::TIMEOUT_MIN));
    bus(1'b1, sps_pkg::ADDR_TIMEOUT, 32'h3ff);
    bus(1'b0, sps_pkg::ADDR_TIMEOUT, 32'h0);
    chk(r, 32'(sps_pkg::TIMEOUT_MAX));
    bus(1'b1, sps_pkg::ADDR_TIMEOUT, 32'h1e);
    bus(1'b1, sps_pkg::ADDR_CTRL, 32'h6);
    bus(1'b0, sps_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h6);
    bus(1'b0, 32'h10, 32'h0);
    chk(r, 32'h0);
    chk(32'(hresp), 32'h0);
    for (int i = 0; i < 7; i++) begin
      @(posedge hclk);
      code_req <= rows[i][10:8];
      wait_ev(rows[i][3:0], 2000);
      chk(32'(ev & rows[i][3:0]), 32'(rows[i][3:0]));
      chk(32'(position), 32'(rows[i][6:4]));
    end
    code_req <= 3'h0;
    wait_ev(4'h9, 700);
    chk(32'(n), 32'd700);
    // Wrap from top, restart by a second step, code word locked out
    req(3'h1);
    wait_ev(4'h8, 20);
    chk(32'(change_initiated), 32'h1);
    repeat (400) @(posedge hclk);
    code_req <= 3'h4;
    req(3'h1);
    wait_ev(4'h1, 2000);
    chk(32'(n >= 595 && n <= 610), 32'h1);
    chk(32'(position), 32'h2);
    bus(1'b0, sps_pkg::ADDR_SAVED, 32'h0);
    chk(r, 32'h2);
    // Both paths to confirm mode
    bus(1'b1, sps_pkg::ADDR_CTRL, 32'h1e);
    req(3'h1);
    repeat (50) @(posedge hclk);
    req(3'h2);
    wait_ev(4'h1, 10);
    chk(32'(position), 32'h3);
    req(3'h1);
    wait_ev(4'h4, 1000);
    chk(32'(step_confirm_alarm), 32'h1);
    chk(32'(position), 32'h3);
    repeat (700) @(posedge hclk);
    chk(32'(step_confirm_alarm), 32'h0);
    // The step confirm must not serve the code path
    code_req <= 3'h5;
    req(3'h2);
    wait_ev(4'h1, 30);
    chk(32'(n), 32'd30);
    req(3'h4);
    wait_ev(4'h1, 10);
    chk(32'(position), 32'h5);
    // Unconfirmed code request keeps the old position and raises its alarm
    code_req <= 3'h6;
    repeat (700) @(posedge hclk);
    chk(32'(code_confirm_alarm), 32'h1);
    chk(32'(position), 32'h5);
    // Restart without power loss restores the kept position
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_ev(4'h1, 20);
    chk(32'(position), 32'h5);
    // Synchronise mode: hold 0 with alarm, then adopt the standing code word
    bus(1'b1, sps_pkg::ADDR_CTRL, 32'h3e);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'(startup_alarm), 32'h1);
    chk(32'(position), 32'h0);
    wait_ev(4'h1, 30);
    chk(32'(position), 32'h6);
    chk(32'(startup_alarm), 32'h0);
    close_out();
  end
endmodule

// [bench/sps_ctl_model.sv]
// Stand-in for the user logic that drives the selector's control operands
module sps_ctl_model #(
  parameter int GAP = 10
) (
  input  wire logic       hclk,
  input  wire logic [2:0] reqs,
  input  wire logic [2:0] code_req,
  output logic            step_input,
  output logic            step_confirm_input,
  output logic            code_confirm_input,
  output logic            code_bit0_input,
  output logic            code_bit1_input,
  output logic            code_bit2_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines settle at the first edge, well inside the reset hold
  int   gap = 1000;
  logic pend = 1'b0;
  // One-cycle pulses; a step asked for too soon is held back, not lost
  always @(posedge hclk) begin
    gap <= gap + 1;
    step_input <= 1'b0;
    step_confirm_input <= reqs[1];
    code_confirm_input <= reqs[2];
    {code_bit2_input, code_bit1_input, code_bit0_input} <= code_req;
    if ((reqs[0] || pend) && gap >= GAP) begin
      step_input <= 1'b1;
      gap <= 0;
      pend <= 1'b0;
    end else if (reqs[0]) begin
      pend <= 1'b1;
    end
  end
endmodule

// [bench/sps_selector_properties.sv]
// Port-level checks on the position selector switch
module sps_selector_properties #(
  parameter int TICK_CYCLES = 2
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       step_input,
  input  wire logic       code_bit0_input,
  input  wire logic       code_bit1_input,
  input  wire logic       code_bit2_input,
  input  wire logic [2:0] position,
  input  wire logic [6:0] position_flags,
  input  wire logic       position_in_use,
  input  wire logic       change_initiated,
  input  wire logic       step_confirm_alarm,
  input  wire logic       code_range_alarm,
  input  wire logic       startup_alarm
);
  timeunit 1ns;
  timeprecision 1ns;
  // Alarm window; one tick short allowed, tick phase runs free
  localparam int LO = 299 * TICK_CYCLES - 2;
  localparam int HI = 300 * TICK_CYCLES + 2;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] code;
  int         rng_cnt;
  int         stp_cnt;
  assign code = {code_bit2_input, code_bit1_input, code_bit0_input};
  // Cycles the range and step alarms have stood high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rng_cnt <= 0;
      stp_cnt <= 0;
    end else begin
      rng_cnt <= code_range_alarm ? rng_cnt + 1 : 0;
      stp_cnt <= step_confirm_alarm ? stp_cnt + 1 : 0;
    end
  end
  flags_match_a: assert property (position_flags == 7'((8'h01 << position) >> 1))
    else $error("position flags disagree with position");
  pos_announce_a: assert property ($changed(position) |-> position_in_use)
    else $error("position changed without in-use pulse");
  use_pulse_a: assert property (position_in_use |=> !position_in_use)
    else $error("in-use pulse longer than one cycle");
  init_cause_a: assert property (change_initiated |-> ($past(step_input) &&
    !$past(step_input, 2)) || $past(code) != $past(code, 2))
    else $error("change flagged without a request");
  rest_quiet_a: assert property ((code == 3'h0 && $past(code) != 3'h0 &&
    !$rose(step_input)) |=> !change_initiated)
    else $error("rest word started a change");
  hold_pos_a: assert property ($rose(step_confirm_alarm) |-> $stable(position))
    else $error("position moved on unconfirmed step");
  startup_zero_a: assert property (startup_alarm |-> position == 3'h0)
    else $error("startup alarm with nonzero position");
  rng_len_a: assert property ($fell(code_range_alarm) |-> rng_cnt >= LO && rng_cnt <= HI)
    else $error("range alarm length wrong");
  stp_len_a: assert property ($fell(step_confirm_alarm) |-> stp_cnt >= LO && stp_cnt <= HI)
    else $error("step alarm length wrong");
  cover property ($rose(code_range_alarm));
  cover property ($rose(step_confirm_alarm));
  cover property (position_in_use && position == 3'h1);
endmodule
bind sps_selector_top sps_selector_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .hclk, .hresetn, .step_input, .code_bit0_input, .code_bit1_input, .code_bit2_input,
  .position, .position_flags, .position_in_use, .change_initiated,
  .step_confirm_alarm, .code_range_alarm, .startup_alarm
);

// [rtl/sps_nv_store.sv]
// Retained storage for settings and the saved position, cleared only at power-on
module sps_nv_store (
  input  wire logic       clk,
  input  wire logic       por_n,
  input  wire logic       pos_we,
  input  wire logic [2:0] pos_wdata,
  input  wire logic       cfg_we,
  input  wire logic [6:0] cfg_wdata,
  input  wire logic       tmo_we,
  input  wire logic [9:0] tmo_wdata,
  output logic      [2:0] saved_pos,
  output logic      [6:0] cfg,
  output logic      [9:0] tmo
);

  typedef struct packed {
    logic [2:0] pos;
    logic [6:0] cfg;
    logic [9:0] tmo;
  } sps_nv_t;

  sps_nv_t q;
  sps_nv_t next_q;

  // Write ports; untouched words keep their value
  always_comb begin
    next_q = q;
    if (pos_we) begin
      next_q.pos = pos_wdata;
    end
    if (cfg_we) begin
      next_q.cfg = cfg_wdata;
    end
    if (tmo_we) begin
      next_q.tmo = tmo_wdata;
    end
  end

  // Only power-on clears; a relay restart on hresetn keeps the contents
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      q <= '{pos: sps_pkg::POS_REST, cfg: sps_pkg::CTRL_RESET, tmo: sps_pkg::TIMEOUT_RESET};
    end else begin
      q <= next_q;
    end
  end

  assign saved_pos = q.pos;
  assign cfg       = q.cfg;
  assign tmo       = q.tmo;

endmodule

// [rtl/sps_pkg.sv]
// Shared constants and types for the position selector switch
package sps_pkg;

  // Clock and timebase
  localparam int CLK_HZ          = 10_000_000;
  localparam int TICK_US         = 10_000;
  localparam int TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * TICK_US;

  // Timeout unit, alarm length and start-up hold, each with its tick count
  localparam int          TENTH_MS        = 100;
  localparam logic [12:0] TICKS_PER_TENTH = 13'(TENTH_MS * 1000 / TICK_US);
  localparam int          ALARM_MS        = 3000;
  localparam logic [8:0]  ALARM_TICKS     = 9'(ALARM_MS * 1000 / TICK_US);
  localparam int          SYNC_HOLD_US    = 40_000;
  localparam logic [3:0]  SYNC_HOLD_TICKS = 4'(SYNC_HOLD_US / TICK_US);

  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
  localparam logic [31:0] ADDR_TIMEOUT = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS  = 32'h0000_0008;
  localparam logic [31:0] ADDR_SAVED   = 32'h0000_000c;

  // Control word layout
  localparam int CTRL_TOP_LSB   = 0;
  localparam int CTRL_STEP_MODE = 3;
  localparam int CTRL_CODE_MODE = 4;
  localparam int CTRL_PWR_LSB   = 5;
  localparam int CTRL_WIDTH     = 7;

  // Status word layout
  localparam int STAT_ACTIVE_LSB = 0;
  localparam int STAT_PRESEL_LSB = 3;
  localparam int STAT_STP_ALARM  = 6;
  localparam int STAT_CACK_ALARM = 7;
  localparam int STAT_RNG_ALARM  = 8;
  localparam int STAT_PWR_ALARM  = 9;
  localparam int STAT_BUSY       = 10;

  // Reset values and limits
  localparam logic [6:0] CTRL_RESET    = 7'h07;
  localparam logic [9:0] TIMEOUT_RESET = 10'h032;
  localparam logic [9:0] TIMEOUT_MIN   = 10'h01e;
  localparam logic [9:0] TIMEOUT_MAX   = 10'h258;
  localparam logic [2:0] POS_FIRST     = 3'h1;
  localparam logic [2:0] POS_REST      = 3'h0;

  // Power-up modes
  localparam logic [1:0] PWR_RESTORE      = 2'h0;
  localparam logic [1:0] PWR_SYNC         = 2'h1;
  localparam logic [1:0] PWR_SYNC_RESTORE = 2'h2;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_SYNC_HOLD,
    ST_IDLE,
    ST_STEP,
    ST_CODE
  } sps_state_t;

endpackage

// [rtl/sps_selector_top.sv]
// Position selector switch core with its AHB-Lite register slave
//
// The AHB-Lite slave port and the register addresses were decided locally.
module sps_selector_top #(
  parameter int TICK_CYCLES = sps_pkg::TICK_CYCLES_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        step_input,
  input  wire logic        step_confirm_input,
  input  wire logic        code_bit0_input,
  input  wire logic        code_bit1_input,
  input  wire logic        code_bit2_input,
  input  wire logic        code_confirm_input,
  output logic      [2:0]  position,
  output logic      [6:0]  position_flags,
  output logic             position_in_use,
  output logic             change_initiated,
  output logic             step_confirm_alarm,
  output logic             code_confirm_alarm,
  output logic             code_range_alarm,
  output logic             startup_alarm
);

  typedef struct packed {
    sps_pkg::sps_state_t st;
    logic [16:0]         tick_cnt;
    logic                tick;
    logic                step_d;
    logic                sack_d;
    logic                cack_d;
    logic [2:0]          code_d;
    logic [2:0]          active;
    logic [2:0]          presel;
    logic [12:0]         timer;
    logic [3:0]          hold;
    logic [8:0]          stp_cnt;
    logic [8:0]          cack_cnt;
    logic [8:0]          rng_cnt;
    logic                stp_alarm;
    logic                cack_alarm;
    logic                rng_alarm;
    logic                pwr_alarm;
    logic [6:0]          flags;
    logic                in_use;
    logic                initiated;
    logic                dp_wr;
    logic [31:0]         dp_addr;
    logic [31:0]         rdata;
    logic                readyout;
    logic                resp;
  } sps_regs_t;

  localparam sps_regs_t RESET_Q = '{st: sps_pkg::ST_BOOT, readyout: 1'b1, default: '0};

  sps_regs_t   q;
  sps_regs_t   next_q;

  logic [2:0]  saved_pos;
  logic [6:0]  cfg;
  logic [9:0]  tmo;
  logic        nv_pos_we;
  logic [2:0]  nv_pos_wdata;
  logic        nv_cfg_we;
  logic [6:0]  nv_cfg_wdata;
  logic        nv_tmo_we;
  logic [9:0]  nv_tmo_wdata;

  logic [2:0]  word;
  logic [2:0]  top;
  logic [1:0]  pwr_mode;
  logic        step_ack_mode;
  logic        code_ack_mode;
  logic        step_rise;
  logic        sack_rise;
  logic        cack_rise;
  logic        code_chg;
  logic        timer_exp;
  logic [12:0] full;
  logic        do_apply;
  logic [2:0]  apply_val;
  logic        stp_load;
  logic        cack_load;
  logic        rng_load;
  logic        accept;

  // Settings and saved position survive a restart on hresetn
  sps_nv_store u_nv (
    .clk       (hclk),
    .por_n     (por_n),
    .pos_we    (nv_pos_we),
    .pos_wdata (nv_pos_wdata),
    .cfg_we    (nv_cfg_we),
    .cfg_wdata (nv_cfg_wdata),
    .tmo_we    (nv_tmo_we),
    .tmo_wdata (nv_tmo_wdata),
    .saved_pos (saved_pos),
    .cfg       (cfg),
    .tmo       (tmo)
  );

  // Position valid for the current top
  function automatic logic in_range(input logic [2:0] v, input logic [2:0] t);
    in_range = (v != sps_pkg::POS_REST) && (v <= t);
  endfunction

  // Next step position with wrap at the top
  function automatic logic [2:0] step_next(input logic [2:0] v, input logic [2:0] t);
    if (v >= t) begin
      step_next = sps_pkg::POS_FIRST;
    end else begin
      step_next = v + 3'h1;
    end
  endfunction

  // Alarm duration counter: a new event reloads, the tick drains
  function automatic logic [8:0] alarm_cnt(input logic load, input logic tk,
                                           input logic [8:0] c);
    if (load) begin
      alarm_cnt = sps_pkg::ALARM_TICKS;
    end else if (tk && (c != 9'h000)) begin
      alarm_cnt = c - 9'h001;
    end else begin
      alarm_cnt = c;
    end
  endfunction

  // Decoded settings and input events
  always_comb begin
    word          = {code_bit2_input, code_bit1_input, code_bit0_input};
    top           = cfg[sps_pkg::CTRL_TOP_LSB +: 3];
    pwr_mode      = cfg[sps_pkg::CTRL_PWR_LSB +: 2];
    step_ack_mode = cfg[sps_pkg::CTRL_STEP_MODE];
    code_ack_mode = cfg[sps_pkg::CTRL_CODE_MODE];
    step_rise     = step_input & ~q.step_d;
    sack_rise     = step_confirm_input & ~q.sack_d;
    cack_rise     = code_confirm_input & ~q.cack_d;
    code_chg      = (word != q.code_d) && (word != sps_pkg::POS_REST);
    full          = {3'h0, tmo} * sps_pkg::TICKS_PER_TENTH;
    timer_exp     = q.tick && (q.timer == 13'h0001);
    accept        = hsel & hready & htrans[1];
  end

  // Whole next state: timebase, sequencer, alarms, outputs and bus
  always_comb begin
    next_q       = q;
    do_apply     = 1'b0;
    apply_val    = q.presel;
    stp_load     = 1'b0;
    cack_load    = 1'b0;
    rng_load     = 1'b0;
    nv_cfg_we    = 1'b0;
    nv_cfg_wdata = cfg;
    nv_tmo_we    = 1'b0;
    nv_tmo_wdata = tmo;
    next_q.in_use    = 1'b0;
    next_q.initiated = 1'b0;

    // Free-running 10 ms tick
    if (q.tick_cnt == 17'(TICK_CYCLES - 1)) begin
      next_q.tick_cnt = 17'h0_0000;
      next_q.tick     = 1'b1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 17'h0_0001;
      next_q.tick     = 1'b0;
    end

    next_q.step_d = step_input;
    next_q.sack_d = step_confirm_input;
    next_q.cack_d = code_confirm_input;
    next_q.code_d = word;

    unique case (q.st)
      // First cycle after a restart picks the power-up behaviour
      sps_pkg::ST_BOOT: begin
        if ((pwr_mode == sps_pkg::PWR_SYNC) || (pwr_mode == sps_pkg::PWR_SYNC_RESTORE)) begin
          next_q.st        = sps_pkg::ST_SYNC_HOLD;
          next_q.hold      = sps_pkg::SYNC_HOLD_TICKS;
          next_q.active    = sps_pkg::POS_REST;
          next_q.pwr_alarm = 1'b1;
        end else begin
          next_q.st = sps_pkg::ST_IDLE;
          if (in_range(saved_pos, top)) begin
            do_apply  = 1'b1;
            apply_val = saved_pos;
          end else begin
            next_q.active    = sps_pkg::POS_REST;
            next_q.pwr_alarm = 1'b1;
          end
        end
      end
      // Hold position 0, then adopt the code word without timeout or confirm
      sps_pkg::ST_SYNC_HOLD: begin
        if (q.tick) begin
          if (q.hold > 4'h1) begin
            next_q.hold = q.hold - 4'h1;
          end else begin
            next_q.st = sps_pkg::ST_IDLE;
            if (in_range(word, top)) begin
              do_apply  = 1'b1;
              apply_val = word;
            end else if ((pwr_mode == sps_pkg::PWR_SYNC_RESTORE) &&
                         in_range(saved_pos, top)) begin
              do_apply  = 1'b1;
              apply_val = saved_pos;
            end
          end
        end
      end
      // Waiting for the first activity on either path; step wins a tie
      sps_pkg::ST_IDLE: begin
        if (step_rise) begin
          next_q.presel    = step_next(q.active, top);
          next_q.timer     = full;
          next_q.initiated = 1'b1;
          next_q.st        = sps_pkg::ST_STEP;
        end else if (code_chg) begin
          if (in_range(word, top)) begin
            next_q.presel    = word;
            next_q.timer     = full;
            next_q.initiated = 1'b1;
            next_q.st        = sps_pkg::ST_CODE;
          end else begin
            rng_load = 1'b1;
          end
        end
      end
      // Step sequence: code word is ignored until it ends
      sps_pkg::ST_STEP: begin
        if (step_rise) begin
          next_q.presel    = step_next(q.presel, top);
          next_q.timer     = full;
          next_q.initiated = 1'b1;
        end else if (step_ack_mode && sack_rise) begin
          do_apply  = 1'b1;
          next_q.st = sps_pkg::ST_IDLE;
        end else if (timer_exp) begin
          next_q.st = sps_pkg::ST_IDLE;
          if (step_ack_mode) begin
            stp_load = 1'b1;
          end else begin
            do_apply = 1'b1;
          end
        end else if (q.tick) begin
          next_q.timer = q.timer - 13'h0001;
        end
      end
      // Code sequence: step input is ignored until it ends
      sps_pkg::ST_CODE: begin
        if (code_chg) begin
          next_q.timer = full;
          if (in_range(word, top)) begin
            next_q.presel    = word;
            next_q.initiated = 1'b1;
          end else begin
            rng_load = 1'b1;
          end
        end else if (code_ack_mode && cack_rise) begin
          do_apply  = 1'b1;
          next_q.st = sps_pkg::ST_IDLE;
        end else if (timer_exp) begin
          next_q.st = sps_pkg::ST_IDLE;
          if (code_ack_mode) begin
            cack_load = 1'b1;
          end else begin
            do_apply = 1'b1;
          end
        end else if (q.tick) begin
          next_q.timer = q.timer - 13'h0001;
        end
      end
      default: begin
        next_q.st = sps_pkg::ST_IDLE;
      end
    endcase

    // Applying a position also clears a pending start-up alarm
    if (do_apply) begin
      next_q.active    = apply_val;
      next_q.in_use    = 1'b1;
      next_q.pwr_alarm = 1'b0;
    end

    // Binary and one-hot leave the same flip-flop stage together
    if (next_q.active == sps_pkg::POS_REST) begin
      next_q.flags = 7'h00;
    end else begin
      next_q.flags = 7'(7'h01 << (next_q.active - 3'h1));
    end

    // Timed alarms; a reload in the drain cycle wins
    next_q.stp_cnt    = alarm_cnt(stp_load, q.tick, q.stp_cnt);
    next_q.cack_cnt   = alarm_cnt(cack_load, q.tick, q.cack_cnt);
    next_q.rng_cnt    = alarm_cnt(rng_load, q.tick, q.rng_cnt);
    next_q.stp_alarm  = (next_q.stp_cnt != 9'h000);
    next_q.cack_alarm = (next_q.cack_cnt != 9'h000);
    next_q.rng_alarm  = (next_q.rng_cnt != 9'h000);

    // Bus address phase: latch write target, prepare read data
    next_q.dp_wr    = accept & hwrite & (hsize == sps_pkg::HSIZE_WORD);
    next_q.dp_addr  = haddr;
    next_q.readyout = 1'b1;
    next_q.resp     = 1'b0;
    if (accept && !hwrite) begin
      next_q.rdata = 32'h0000_0000;
      unique case (haddr)
        sps_pkg::ADDR_CTRL: begin
          next_q.rdata[sps_pkg::CTRL_WIDTH-1:0] = cfg;
        end
        sps_pkg::ADDR_TIMEOUT: begin
          next_q.rdata[9:0] = tmo;
        end
        sps_pkg::ADDR_STATUS: begin
          next_q.rdata[sps_pkg::STAT_ACTIVE_LSB +: 3] = q.active;
          next_q.rdata[sps_pkg::STAT_PRESEL_LSB +: 3] = q.presel;
          next_q.rdata[sps_pkg::STAT_STP_ALARM]       = q.stp_alarm;
          next_q.rdata[sps_pkg::STAT_CACK_ALARM]      = q.cack_alarm;
          next_q.rdata[sps_pkg::STAT_RNG_ALARM]       = q.rng_alarm;
          next_q.rdata[sps_pkg::STAT_PWR_ALARM]       = q.pwr_alarm;
          next_q.rdata[sps_pkg::STAT_BUSY]            = (q.st == sps_pkg::ST_STEP) ||
                                                        (q.st == sps_pkg::ST_CODE);
        end
        sps_pkg::ADDR_SAVED: begin
          next_q.rdata[2:0] = saved_pos;
        end
        default: begin
          next_q.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Bus data phase: a zero top and an out-of-range timeout are clamped; power-up mode 3 is stored as written
    if (q.dp_wr && (q.dp_addr == sps_pkg::ADDR_CTRL)) begin
      nv_cfg_we    = 1'b1;
      nv_cfg_wdata = hwdata[sps_pkg::CTRL_WIDTH-1:0];
      if (hwdata[sps_pkg::CTRL_TOP_LSB +: 3] == sps_pkg::POS_REST) begin
        nv_cfg_wdata[sps_pkg::CTRL_TOP_LSB +: 3] = sps_pkg::POS_FIRST;
      end
    end
    if (q.dp_wr && (q.dp_addr == sps_pkg::ADDR_TIMEOUT)) begin
      nv_tmo_we = 1'b1;
      if (hwdata[31:10] != 22'h00_0000 || hwdata[9:0] > sps_pkg::TIMEOUT_MAX) begin
        nv_tmo_wdata = sps_pkg::TIMEOUT_MAX;
      end else if (hwdata[9:0] < sps_pkg::TIMEOUT_MIN) begin
        nv_tmo_wdata = sps_pkg::TIMEOUT_MIN;
      end else begin
        nv_tmo_wdata = hwdata[9:0];
      end
    end
  end

  // Saved position follows every apply; software may preset it otherwise
  always_comb begin
    if (do_apply) begin
      nv_pos_we    = 1'b1;
      nv_pos_wdata = apply_val;
    end else begin
      nv_pos_we    = q.dp_wr && (q.dp_addr == sps_pkg::ADDR_SAVED);
      nv_pos_wdata = hwdata[2:0];
    end
  end

  // One register stage for all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RESET_Q;
    end else begin
      q <= next_q;
    end
  end

  assign hrdata             = q.rdata;
  assign hreadyout          = q.readyout;
  assign hresp              = q.resp;
  assign position           = q.active;
  assign position_flags     = q.flags;
  assign position_in_use    = q.in_use;
  assign change_initiated   = q.initiated;
  assign step_confirm_alarm = q.stp_alarm;
  assign code_confirm_alarm = q.cack_alarm;
  assign code_range_alarm   = q.rng_alarm;
  assign startup_alarm      = q.pwr_alarm;

endmodule
